// >>> shared/drive_comm_regs.vh
// Purpose: Register addresses, field positions and reset values of the drive
//          communication register bank.
// Assumes: 16-bit word registers, 16-bit word addresses.
// Notes:   Included by src/drive_comm_control_status_regs.v.
//
// Functional notes
// - Run command acts by code 0001H-0008H
// - Frequency reference 0 to fmax, 0.01 Hz
// - Loop setpoint accepts 0 to 1000
// - Loop feedback accepts 0 to 1000
// - Torque reference signed -3000 to +3000
// - Separate forward/reverse frequency ceilings, 0 to fmax
// - Motoring torque ceiling accepts 0 to 3000
// - Braking torque ceiling accepts 0 to 3000
// - Control word bits 1-0 select motor
// - Control bit 2 disables torque control
// - Control bit 3 clears power count
// - Control bit 4 requests pre-excitation
// - Control bit 5 requests DC braking
// - Virtual input image holds 10 bits
// - Virtual output image holds 4 bits
// - Voltage reference accepts 0 to 1000
// - Two analog output references, -1000 to +1000
// - State word one reports state code
// - State two bit 0 ready to run
// - State two bits 2-1 motor in use
// - State two bit 3 machine type
// - State two bit 4 overload alarm
// - State two bits 6-5 command source
`ifndef DRIVE_COMM_REGS_VH
`define DRIVE_COMM_REGS_VH

// ----------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------
`define ADDR_RUN_COMMAND        16'h2000
`define ADDR_FREQ_REFERENCE     16'h2001
`define ADDR_LOOP_SETPOINT      16'h2002
`define ADDR_LOOP_FEEDBACK      16'h2003
`define ADDR_TORQUE_REFERENCE   16'h2004
`define ADDR_FWD_FREQ_CEILING   16'h2005
`define ADDR_REV_FREQ_CEILING   16'h2006
`define ADDR_MOTOR_TORQUE_CEIL  16'h2007
`define ADDR_BRAKE_TORQUE_CEIL  16'h2008
`define ADDR_SPECIAL_CONTROL    16'h2009
`define ADDR_VIRTUAL_INPUT      16'h200A
`define ADDR_VIRTUAL_OUTPUT     16'h200B
`define ADDR_VOLTAGE_REFERENCE  16'h200C
`define ADDR_AOUT_REFERENCE_1   16'h200D
`define ADDR_AOUT_REFERENCE_2   16'h200E
`define ADDR_STATE_PRIMARY      16'h2100
`define ADDR_STATE_SECONDARY    16'h2101

// ----------------------------------------------------------------
// Run command codes
// ----------------------------------------------------------------
`define CMD_FWD_RUN             16'h0001
`define CMD_REV_RUN             16'h0002
`define CMD_FWD_JOG             16'h0003
`define CMD_REV_JOG             16'h0004
`define CMD_STOP                16'h0005
`define CMD_COAST_STOP          16'h0006
`define CMD_FAULT_RESET         16'h0007
`define CMD_JOG_STOP            16'h0008

// ----------------------------------------------------------------
// Primary state codes
// ----------------------------------------------------------------
`define STATE_FWD_RUNNING       16'h0001
`define STATE_REV_RUNNING       16'h0002
`define STATE_STOPPED           16'h0003
`define STATE_FAULTED           16'h0004
`define STATE_UNDERVOLTAGE_OFF  16'h0005
`define STATE_PRE_EXCITED       16'h0006

// ----------------------------------------------------------------
// Ranges
// ----------------------------------------------------------------
`define PERCENT_MAX             16'h03E8
`define TORQUE_MAX              16'h0BB8
`define TORQUE_MIN_NEG          16'hF448
`define AOUT_MIN_NEG            16'hFC18
`define VIN_WIDTH               10
`define VOUT_WIDTH              4

// ----------------------------------------------------------------
// Special control word fields
// ----------------------------------------------------------------
`define SCW_MOTOR_LSB           0
`define SCW_MOTOR_MSB           1
`define SCW_TORQUE_OFF_BIT      2
`define SCW_POWER_CLEAR_BIT     3
`define SCW_PRE_EXCITE_BIT      4
`define SCW_DC_BRAKE_BIT        5
`define SCW_USED_MASK           16'h003F

// ----------------------------------------------------------------
// Secondary state word fields
// ----------------------------------------------------------------
`define SSW_READY_BIT           0
`define SSW_MOTOR_LSB           1
`define SSW_MOTOR_MSB           2
`define SSW_SYNC_BIT            3
`define SSW_OVERLOAD_BIT        4
`define SSW_SOURCE_LSB          5
`define SSW_SOURCE_MSB          6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RESET_WORD              16'h0000
`define RESET_STATE_PRIMARY     16'h0003

`endif

// >>> src/drive_comm_control_status_regs.v
// Purpose: Communication register bank between a serial bus master and the
//          drive's control and measurement logic.
// Assumes: Frame decoder on mclk delivers one-cycle write and read strobes.
// Notes:   Out-of-range writes are rejected whole; the register keeps its value.
`timescale 1ns/1ps
`default_nettype none
`include "drive_comm_regs.vh"

module drive_comm_control_status_regs #(
  parameter [15:0] MAX_OUTPUT_FREQUENCY = 16'h2710
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        reset_n,
  // Register access from the frame decoder
  input  wire        wrStrobe,
  input  wire        rdStrobe,
  input  wire [15:0] regAddr,
  input  wire [15:0] wrData,
  output reg  [15:0] rdData,
  output reg         rdValid,
  output reg         accessError,
  // Drive state from the control logic
  input  wire [15:0] driveStateCode,
  input  wire        readyToRun,
  input  wire [1:0]  motorInUse,
  input  wire        synchronousMachine,
  input  wire        overloadAlarm,
  input  wire [1:0]  commandSource,
  // Commands and references to the control logic
  output reg  [3:0]  runCommandCode,
  output reg         runCommandPulse,
  output reg  [15:0] frequencyReference,
  output reg  [15:0] loopSetpoint,
  output reg  [15:0] loopFeedback,
  output reg  [15:0] torqueReference,
  output reg  [15:0] forwardFreqCeiling,
  output reg  [15:0] reverseFreqCeiling,
  output reg  [15:0] motoringTorqueCeiling,
  output reg  [15:0] brakingTorqueCeiling,
  output reg  [1:0]  activeMotor,
  output reg         torqueControlOff,
  output reg         powerCountClear,
  output reg         preExcitationRequest,
  output reg         dcBrakeRequest,
  output reg  [9:0]  virtualInputImage,
  output reg  [3:0]  virtualOutputImage,
  output reg  [15:0] voltageReference,
  output reg  [15:0] analogOutReference1,
  output reg  [15:0] analogOutReference2
);

  // ----------------------------------------------------------------
  // Write qualification
  // ----------------------------------------------------------------
  wire signed [15:0] wrSigned  = wrData;
  wire               okFreq    = (wrData <= MAX_OUTPUT_FREQUENCY);
  wire               okPercent = (wrData <= `PERCENT_MAX);
  wire               okTorque  = (wrData <= `TORQUE_MAX);
  wire               okTorqueS = (wrSigned >= $signed(`TORQUE_MIN_NEG)) &&
                                 (wrSigned <= $signed(`TORQUE_MAX));
  wire               okAout    = (wrSigned >= $signed(`AOUT_MIN_NEG)) &&
                                 (wrSigned <= $signed(`PERCENT_MAX));
  wire               okRunCode = (wrData >= `CMD_FWD_RUN) && (wrData <= `CMD_JOG_STOP);

  reg  [15:0] specialControl_reg;
  reg  [15:0] runCommand_reg;
  reg         writeOk;
  reg         mapped;
  reg  [15:0] readWord;

  // Secondary state word assembled live from the control logic
  wire [15:0] stateSecondary = {9'h000,
                                commandSource,
                                overloadAlarm,
                                synchronousMachine,
                                motorInUse,
                                readyToRun};

  always @* begin
    writeOk  = 1'b0;
    mapped   = 1'b1;
    readWord = 16'h0000;
    case (regAddr)
      `ADDR_RUN_COMMAND: begin
        writeOk  = okRunCode;
        readWord = runCommand_reg;
      end
      `ADDR_FREQ_REFERENCE: begin
        writeOk  = okFreq;
        readWord = frequencyReference;
      end
      `ADDR_LOOP_SETPOINT: begin
        writeOk  = okPercent;
        readWord = loopSetpoint;
      end
      `ADDR_LOOP_FEEDBACK: begin
        writeOk  = okPercent;
        readWord = loopFeedback;
      end
      `ADDR_TORQUE_REFERENCE: begin
        writeOk  = okTorqueS;
        readWord = torqueReference;
      end
      `ADDR_FWD_FREQ_CEILING: begin
        writeOk  = okFreq;
        readWord = forwardFreqCeiling;
      end
      `ADDR_REV_FREQ_CEILING: begin
        writeOk  = okFreq;
        readWord = reverseFreqCeiling;
      end
      `ADDR_MOTOR_TORQUE_CEIL: begin
        writeOk  = okTorque;
        readWord = motoringTorqueCeiling;
      end
      `ADDR_BRAKE_TORQUE_CEIL: begin
        writeOk  = okTorque;
        readWord = brakingTorqueCeiling;
      end
      `ADDR_SPECIAL_CONTROL: begin
        writeOk  = 1'b1;
        readWord = specialControl_reg;
      end
      `ADDR_VIRTUAL_INPUT: begin
        writeOk  = (wrData[15:`VIN_WIDTH] == 6'h00);
        readWord = {6'h00, virtualInputImage};
      end
      `ADDR_VIRTUAL_OUTPUT: begin
        writeOk  = (wrData[15:`VOUT_WIDTH] == 12'h000);
        readWord = {12'h000, virtualOutputImage};
      end
      `ADDR_VOLTAGE_REFERENCE: begin
        writeOk  = okPercent;
        readWord = voltageReference;
      end
      `ADDR_AOUT_REFERENCE_1: begin
        writeOk  = okAout;
        readWord = analogOutReference1;
      end
      `ADDR_AOUT_REFERENCE_2: begin
        writeOk  = okAout;
        readWord = analogOutReference2;
      end
      `ADDR_STATE_PRIMARY: begin
        writeOk  = 1'b0;
        readWord = driveStateCode;
      end
      `ADDR_STATE_SECONDARY: begin
        writeOk  = 1'b0;
        readWord = stateSecondary;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  wire doWrite = wrStrobe && writeOk;

  // ----------------------------------------------------------------
  // Writable registers
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      runCommand_reg        <= `RESET_WORD;
      runCommandCode        <= 4'h0;
      runCommandPulse       <= 1'b0;
      frequencyReference    <= `RESET_WORD;
      loopSetpoint          <= `RESET_WORD;
      loopFeedback          <= `RESET_WORD;
      torqueReference       <= `RESET_WORD;
      forwardFreqCeiling    <= `RESET_WORD;
      reverseFreqCeiling    <= `RESET_WORD;
      motoringTorqueCeiling <= `RESET_WORD;
      brakingTorqueCeiling  <= `RESET_WORD;
      specialControl_reg    <= `RESET_WORD;
      virtualInputImage     <= 10'h000;
      virtualOutputImage    <= 4'h0;
      voltageReference      <= `RESET_WORD;
      analogOutReference1   <= `RESET_WORD;
      analogOutReference2   <= `RESET_WORD;
    end else begin
      runCommandPulse <= 1'b0;
      if (doWrite) begin
        case (regAddr)
          `ADDR_RUN_COMMAND: begin
            runCommand_reg  <= wrData;
            runCommandCode  <= wrData[3:0];
            runCommandPulse <= 1'b1;
          end
          `ADDR_FREQ_REFERENCE:    frequencyReference    <= wrData;
          `ADDR_LOOP_SETPOINT:     loopSetpoint          <= wrData;
          `ADDR_LOOP_FEEDBACK:     loopFeedback          <= wrData;
          `ADDR_TORQUE_REFERENCE:  torqueReference       <= wrData;
          `ADDR_FWD_FREQ_CEILING:  forwardFreqCeiling    <= wrData;
          `ADDR_REV_FREQ_CEILING:  reverseFreqCeiling    <= wrData;
          `ADDR_MOTOR_TORQUE_CEIL: motoringTorqueCeiling <= wrData;
          `ADDR_BRAKE_TORQUE_CEIL: brakingTorqueCeiling  <= wrData;
          `ADDR_SPECIAL_CONTROL:   specialControl_reg    <= wrData & `SCW_USED_MASK;
          `ADDR_VIRTUAL_INPUT:     virtualInputImage     <= wrData[`VIN_WIDTH-1:0];
          `ADDR_VIRTUAL_OUTPUT:    virtualOutputImage    <= wrData[`VOUT_WIDTH-1:0];
          `ADDR_VOLTAGE_REFERENCE: voltageReference      <= wrData;
          `ADDR_AOUT_REFERENCE_1:  analogOutReference1   <= wrData;
          `ADDR_AOUT_REFERENCE_2:  analogOutReference2   <= wrData;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Special control word decode
  // ----------------------------------------------------------------
  // Clear stays a one-cycle pulse per write so the energy counter is
  // not held at zero while the bit sits set in the register.
  wire scwWrite = doWrite && (regAddr == `ADDR_SPECIAL_CONTROL);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      activeMotor          <= 2'b00;
      torqueControlOff     <= 1'b0;
      powerCountClear      <= 1'b0;
      preExcitationRequest <= 1'b0;
      dcBrakeRequest       <= 1'b0;
    end else begin
      activeMotor          <= specialControl_reg[`SCW_MOTOR_MSB:`SCW_MOTOR_LSB];
      torqueControlOff     <= specialControl_reg[`SCW_TORQUE_OFF_BIT];
      preExcitationRequest <= specialControl_reg[`SCW_PRE_EXCITE_BIT];
      dcBrakeRequest       <= specialControl_reg[`SCW_DC_BRAKE_BIT];
      powerCountClear      <= scwWrite && wrData[`SCW_POWER_CLEAR_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Read answer and error flag
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData      <= 16'h0000;
      rdValid     <= 1'b0;
      accessError <= 1'b0;
    end else begin
      rdValid     <= rdStrobe;
      rdData      <= rdStrobe ? readWord : rdData;
      accessError <= (rdStrobe && !mapped) || (wrStrobe && !writeOk);
    end
  end

endmodule // drive_comm_control_status_regs
`default_nettype wire

// >>> dv/drive_comm_regs_sva.sv
// Purpose: Port-level checks of the drive communication register bank
// Assumes: One mclk domain, reset_n asynchronous active low
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module drive_comm_regs_sva #(
  parameter [15:0] MAX_OUTPUT_FREQUENCY = 16'h2710
) (
  // Clock, reset and register access
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        wrStrobe,
  input wire logic        rdStrobe,
  input wire logic [15:0] regAddr,
  input wire logic [15:0] wrData,
  input wire logic [15:0] rdData,
  input wire logic        rdValid,
  input wire logic        accessError,
  // Drive side
  input wire logic [15:0] driveStateCode,
  input wire logic [3:0]  runCommandCode,
  input wire logic        runCommandPulse,
  input wire logic [15:0] frequencyReference,
  input wire logic [15:0] torqueReference,
  input wire logic [1:0]  activeMotor,
  input wire logic        torqueControlOff,
  input wire logic        powerCountClear,
  input wire logic        preExcitationRequest,
  input wire logic        dcBrakeRequest,
  input wire logic [9:0]  virtualInputImage
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire logic wrRun = wrStrobe && regAddr == 16'h2000;
  wire logic wrCtl = wrStrobe && regAddr == 16'h2009;

  property p_state_primary;
    rdStrobe && regAddr == 16'h2100 |=> rdValid && rdData == $past(driveStateCode);
  endproperty
  a_state_primary: assert property (p_state_primary)
    else $error("primary state word read wrong");
  property p_run_accept;
    wrRun && wrData >= 16'h0001 && wrData <= 16'h0008
      |=> runCommandPulse && runCommandCode == $past(wrData[3:0]);
  endproperty
  a_run_accept: assert property (p_run_accept)
    else $error("run command not issued");
  property p_run_reject;
    wrRun && (wrData == 16'h0000 || wrData > 16'h0008) |=> accessError && !runCommandPulse;
  endproperty
  a_run_reject: assert property (p_run_reject)
    else $error("bad run code acted on");
  property p_state_write; wrStrobe && regAddr[15:8] == 8'h21 |=> accessError; endproperty
  a_state_write: assert property (p_state_write)
    else $error("state word write not refused");
  property p_freq_accept;
    wrStrobe && regAddr == 16'h2001 && wrData <= MAX_OUTPUT_FREQUENCY
      |=> !accessError && frequencyReference == $past(wrData);
  endproperty
  a_freq_accept: assert property (p_freq_accept)
    else $error("frequency reference not taken");
  property p_torque_reject;
    wrStrobe && regAddr == 16'h2004 && ($signed(wrData) > 3000 || $signed(wrData) < -3000)
      |=> accessError && $stable(torqueReference);
  endproperty
  a_torque_reject: assert property (p_torque_reject)
    else $error("torque reference out of range taken");
  property p_vin_reject;
    wrStrobe && regAddr == 16'h200A && wrData > 16'h03FF
      |=> accessError && $stable(virtualInputImage);
  endproperty
  a_vin_reject: assert property (p_vin_reject)
    else $error("oversized input image taken");
  property p_clear_pulse; wrCtl |=> powerCountClear == $past(wrData[3]); endproperty
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("power count clear pulse wrong");
  property p_motor_select;
    wrCtl |-> ##2 activeMotor == $past(wrData[1:0], 2) && torqueControlOff == $past(wrData[2], 2);
  endproperty
  a_motor_select: assert property (p_motor_select)
    else $error("motor select or torque disable wrong");
  property p_excite_brake;
    wrCtl |-> ##2 preExcitationRequest == $past(wrData[4], 2)
      && dcBrakeRequest == $past(wrData[5], 2);
  endproperty
  a_excite_brake: assert property (p_excite_brake)
    else $error("excitation or brake request wrong");
  c_run_pulse: cover property (runCommandPulse);
  c_refused: cover property (accessError);
  c_clear: cover property (wrCtl ##1 powerCountClear);
endmodule  // drive_comm_regs_sva
`default_nettype wire

// >>> dv/bus_master_model.sv
// Purpose: Bus master behind the frame decoder, one word per request
// Assumes: Requests launched on falling mclk, taken on the next rising edge
// Notes:   Released strobes drop low; address and data are inverted so a stale value cannot pass
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // Clock and answer
  input  wire logic        mclk,
  input  wire logic [15:0] rdData,
  // Requests
  output var  logic        wrStrobe,
  output var  logic        rdStrobe,
  output var  logic [15:0] regAddr,
  output var  logic [15:0] wrData
);
  initial begin
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    regAddr  = 16'h0000;
    wrData   = 16'h0000;
  end
  // Returns mid-cycle after the taking edge, while one-cycle answers stand
  task automatic drop;
    @(negedge mclk);
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    regAddr  = ~regAddr;
    wrData   = ~wrData;
  endtask
  // Single-register write is the only write issued
  task automatic wr_word(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    wrStrobe = 1'b1;
    regAddr  = a;
    wrData   = d;
    drop();
  endtask
  task automatic rd_word(input logic [15:0] a, output logic [15:0] d);
    @(negedge mclk);
    rdStrobe = 1'b1;
    regAddr  = a;
    drop();
    d = rdData;
  endtask
endmodule  // bus_master_model
`default_nettype wire

// >>> dv/drive_comm_control_status_regs_tb_top.sv
// Purpose: Self-checking bench for the drive communication register bank
// Assumes: Master model drives requests on falling mclk
// Notes:   Frequency ceiling shortened to 5000 counts
`timescale 1ns/1ps
`default_nettype none
module drive_comm_control_status_regs_tb_top;
  localparam int MAXF = 5000;
  logic        mclk = 1'b0;
  logic        reset_n, wrStrobe, rdStrobe, rdValid, accessError, runCommandPulse;
  logic        readyToRun, synchronousMachine, overloadAlarm, torqueControlOff;
  logic        powerCountClear, preExcitationRequest, dcBrakeRequest;
  logic [1:0]  motorInUse, commandSource, activeMotor;
  logic [3:0]  runCommandCode, virtualOutputImage;
  logic [9:0]  virtualInputImage;
  logic [15:0] regAddr, wrData, rdData, driveStateCode, frequencyReference, loopSetpoint;
  logic [15:0] loopFeedback, torqueReference, forwardFreqCeiling, reverseFreqCeiling;
  logic [15:0] motoringTorqueCeiling, brakingTorqueCeiling, voltageReference;
  logic [15:0] analogOutReference1, analogOutReference2;
  logic [15:0] modelReg [15];
  int          loBound [15] = '{1, 0, 0, 0, -3000, 0, 0, 0, 0, 0, 0, 0, 0, -1000, -1000};
  int          hiBound [15] = '{8, MAXF, 1000, 1000, 3000, MAXF, MAXF, 3000, 3000, 65535,
                                1023, 15, 1000, 1000, 1000};
  int          fail_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  drive_comm_control_status_regs #(.MAX_OUTPUT_FREQUENCY(16'h1388)) u_dut (
    .mclk, .reset_n, .wrStrobe, .rdStrobe, .regAddr, .wrData, .rdData, .rdValid,
    .accessError, .driveStateCode, .readyToRun, .motorInUse, .synchronousMachine,
    .overloadAlarm, .commandSource, .runCommandCode, .runCommandPulse, .frequencyReference,
    .loopSetpoint, .loopFeedback, .torqueReference, .forwardFreqCeiling, .reverseFreqCeiling,
    .motoringTorqueCeiling, .brakingTorqueCeiling, .activeMotor, .torqueControlOff,
    .powerCountClear, .preExcitationRequest, .dcBrakeRequest, .virtualInputImage,
    .virtualOutputImage, .voltageReference, .analogOutReference1, .analogOutReference2);
  bus_master_model u_master (.mclk, .rdData, .wrStrobe, .rdStrobe, .regAddr, .wrData);

  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Range model decides acceptance; refused writes leave the register alone
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    int i, v;
    bit ok;
    i = a - 16'h2000;
    ok = 1'b0;
    if (a >= 16'h2000 && a <= 16'h200E) begin
      v = (i == 4 || i > 12) ? int'($signed(d)) : int'(d);
      ok = v >= loBound[i] && v <= hiBound[i];
    end
    u_master.wr_word(a, d);
    check(accessError, !ok);
    if (ok) modelReg[i] = (i == 9) ? (d & 16'h003F) : d;
    if (a == 16'h2000) check(runCommandPulse, ok);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic err);
    logic [15:0] d;
    u_master.rd_word(a, d);
    check(d, exp);
    check(rdValid, 1'b1);
    check(accessError, err);
  endtask
  task automatic rd_all;
    foreach (modelReg[i]) rd(16'h2000 + 16'(i), modelReg[i], 1'b0);
    // Register outputs toward the drive must match the model too
    check(runCommandCode, modelReg[0] & 16'h000F);
    check(frequencyReference, modelReg[1]);
    check(loopSetpoint, modelReg[2]);
    check(loopFeedback, modelReg[3]);
    check(torqueReference, modelReg[4]);
    check(forwardFreqCeiling, modelReg[5]);
    check(reverseFreqCeiling, modelReg[6]);
    check(motoringTorqueCeiling, modelReg[7]);
    check(brakingTorqueCeiling, modelReg[8]);
    check(virtualInputImage, modelReg[10]);
    check(virtualOutputImage, modelReg[11]);
    check(voltageReference, modelReg[12]);
    check(analogOutReference1, modelReg[13]);
    check(analogOutReference2, modelReg[14]);
  endtask

  initial begin
    logic [15:0] d;
    reset_n = 1'b0;
    {driveStateCode, readyToRun, motorInUse, synchronousMachine, overloadAlarm} = 21'h000000;
    commandSource = 2'h0;
    foreach (modelReg[i]) modelReg[i] = 16'h0000;
    void'($urandom(32'hF587FA9D));
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    rd_all();
    // Boundaries, one past each boundary, then random values
    foreach (loBound[i]) for (int k = 0; k < 6; k++) begin
      d = 16'(k == 0 ? loBound[i] : k == 1 ? hiBound[i] : k == 2 ? hiBound[i] + 1 :
              k == 3 ? loBound[i] - 1 :
              k == 4 ? loBound[i] + $urandom_range(hiBound[i] - loBound[i], 0) : $urandom);
      wr(16'h2000 + 16'(i), d);
    end
    rd_all();
    for (int c = 0; c < 10; c++) begin
      wr(16'h2000, 16'(c));
      if (c > 0 && c < 9) check(runCommandCode, 16'(c));
    end
    for (int c = 0; c < 64; c++) begin
      d = {10'($urandom_range(1023, 0)), 6'(c)};
      wr(16'h2009, d);
      check(powerCountClear, d[3]);
      @(posedge mclk);
      #1;
      check(activeMotor, d[1:0]);
      check(torqueControlOff, d[2]);
      check(preExcitationRequest, d[4]);
      check(dcBrakeRequest, d[5]);
      check(powerCountClear, 1'b0);
    end
    repeat (8) begin
      @(negedge mclk);
      driveStateCode = 16'($urandom_range(6, 1));
      {readyToRun, motorInUse, synchronousMachine, overloadAlarm} = 5'($urandom);
      commandSource = 2'($urandom_range(2, 0));
      rd(16'h2100, driveStateCode, 1'b0);
      rd(16'h2101, {9'h000, commandSource, overloadAlarm, synchronousMachine, motorInUse,
                    readyToRun}, 1'b0);
      wr(16'h2100 + 16'($urandom_range(1, 0)), 16'($urandom));
    end
    wr(16'h200F, 16'h0001);
    rd(16'h200F, 16'h0000, 1'b1);
    rd_all();
    @(negedge mclk);
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    foreach (modelReg[i]) modelReg[i] = 16'h0000;
    rd_all();
    print_verdict();
  end
endmodule  // drive_comm_control_status_regs_tb_top

bind drive_comm_control_status_regs drive_comm_regs_sva #(
  .MAX_OUTPUT_FREQUENCY(MAX_OUTPUT_FREQUENCY)) u_sva (
  .mclk, .reset_n, .wrStrobe, .rdStrobe, .regAddr, .wrData, .rdData, .rdValid, .accessError,
  .driveStateCode, .runCommandCode, .runCommandPulse, .frequencyReference, .torqueReference,
  .activeMotor, .torqueControlOff, .powerCountClear, .preExcitationRequest, .dcBrakeRequest,
  .virtualInputImage);
`default_nettype wire
